// ---- core/bcr_defs.vh ----
`ifndef BCR_DEFS_VH
`define BCR_DEFS_VH

// register indices; byte address is four times the index
`define BCR_IDX_BRIGHT 6'h04
`define BCR_IDX_BOOST 6'h05
`define BCR_IDX_CTRL 6'h06
`define BCR_IDX_RES_HI 6'h08
`define BCR_IDX_RES_LO 6'h09
`define BCR_IDX_RED 6'h0a
`define BCR_IDX_GREEN 6'h0b
`define BCR_IDX_BLUE 6'h0c

// brightness_control fields
`define BCR_BRI_LSB 0
`define BCR_BRI_MSB 2
`define BCR_BRC_OFF_BIT 4

// boost_voltage field and its legal code range
`define BCR_VPROG_MSB 4
`define BCR_VPROG_MIN 5'h05
`define BCR_VPROG_MAX 5'h14

// main_control fields
`define BCR_NSTBY_BIT 0
`define BCR_EN_BOOST_BIT 1
`define BCR_VOUT_AUTO_BIT 2
`define BCR_AUTOLOAD_BIT 3
`define BCR_SENS_SEL_BIT 4
`define BCR_COMP_SRC_BIT 5

// reset values
`define BCR_RST_BRIGHT 8'h00
`define BCR_RST_BOOST 8'h00
`define BCR_RST_CTRL 8'h04
`define BCR_RST_GAIN 8'h80
`define BCR_RST_RESULT 12'h000

// writable bit masks
`define BCR_MASK_BRIGHT 8'h17
`define BCR_MASK_BOOST 8'h1f
`define BCR_MASK_CTRL 8'h3f

`endif

// ---- core/bcr_sync.v ----
`timescale 1ns/1ps
`default_nettype none

module bcr_sync (
    input wire sys_clk,
    input wire rst_b,
    input wire async_in,
    output wire sync_out
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg level_q;

    // three-stage chain; the level moves only once stages two and three agree
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

    assign sync_out = level_q;
endmodule // bcr_sync

`default_nettype wire

// ---- core/bcr_top.v ----
`include "bcr_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module bcr_top #(
    parameter ADDR_W = 12
) (
    input wire sys_clk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire brightness_pin,
    input wire [11:0] conv_result,
    input wire conv_valid,
    output reg bright_gate_q,
    output reg [7:0] bright_scale_q,
    output reg bright_ext_q,
    output reg [4:0] boost_code_q,
    output reg boost_adaptive_q,
    output reg boost_enable_q,
    output reg autoload_q,
    output reg comp_sensor_source_q,
    output reg sensor_select_q,
    output reg active_q,
    output reg [7:0] red_gain_q,
    output reg [7:0] green_gain_q,
    output reg [7:0] blue_gain_q
);
    reg [7:0] bright_reg_q;
    reg [7:0] boost_reg_q;
    reg [7:0] ctrl_reg_q;
    reg [11:0] result_q;
    reg [7:0] low_shadow_q;
    reg snap_hold_q;
    wire rd_hi;
    wire rd_lo;
    reg [31:0] rdata_d;
    reg hit_d;
    wire [5:0] idx;
    wire aligned;
    wire pin_level;
    wire access;
    wire commit;
    wire wr_ok;

    // clamp a boost code into the documented 5 V .. 20 V span
    function [4:0] bcr_clamp_boost;
        input [4:0] code;
        begin
            if (code < `BCR_VPROG_MIN) begin
                bcr_clamp_boost = `BCR_VPROG_MIN;
            end else if (code > `BCR_VPROG_MAX) begin
                bcr_clamp_boost = `BCR_VPROG_MAX;
            end else begin
                bcr_clamp_boost = code;
            end
        end
    endfunction

    // external brightness input crosses into sys_clk
    bcr_sync u_pin_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .async_in(brightness_pin),
        .sync_out(pin_level)
    );

    // address decode: word aligned, in range, index from byte address
    assign idx = paddr[7:2];
    assign aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:8] == {(ADDR_W-8){1'b0}});
    assign access = psel && penable;
    assign commit = access && pready;
    assign wr_ok = commit && pwrite && pstrb[0] && hit_d;
    assign rd_hi = commit && !pwrite && hit_d && (idx == `BCR_IDX_RES_HI);
    assign rd_lo = commit && !pwrite && hit_d && (idx == `BCR_IDX_RES_LO);

    // read mux and hit detect; unused bits stay zero
    always @* begin
        rdata_d = 32'h0000_0000;
        hit_d = aligned;
        case (idx)
            `BCR_IDX_BRIGHT: rdata_d[7:0] = bright_reg_q;
            `BCR_IDX_BOOST: rdata_d[7:0] = boost_reg_q;
            `BCR_IDX_CTRL: rdata_d[7:0] = ctrl_reg_q;
            `BCR_IDX_RES_HI: rdata_d[3:0] = result_q[11:8];
            `BCR_IDX_RES_LO: rdata_d[7:0] = low_shadow_q;
            `BCR_IDX_RED: rdata_d[7:0] = red_gain_q;
            `BCR_IDX_GREEN: rdata_d[7:0] = green_gain_q;
            `BCR_IDX_BLUE: rdata_d[7:0] = blue_gain_q;
            default: hit_d = 1'b0;
        endcase
    end

    // apb slave: one wait state, answer registered in the first access cycle
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : rdata_d;
            pslverr <= !hit_d;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // software-writable registers, masked so fixed bits stay zero
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bright_reg_q <= `BCR_RST_BRIGHT;
            boost_reg_q <= `BCR_RST_BOOST;
            ctrl_reg_q <= `BCR_RST_CTRL;
            red_gain_q <= `BCR_RST_GAIN;
            green_gain_q <= `BCR_RST_GAIN;
            blue_gain_q <= `BCR_RST_GAIN;
        end else if (wr_ok) begin
            case (idx)
                `BCR_IDX_BRIGHT: bright_reg_q <= pwdata[7:0] & `BCR_MASK_BRIGHT;
                `BCR_IDX_BOOST: boost_reg_q <= pwdata[7:0] & `BCR_MASK_BOOST;
                `BCR_IDX_CTRL: ctrl_reg_q <= pwdata[7:0] & `BCR_MASK_CTRL;
                `BCR_IDX_RED: red_gain_q <= pwdata[7:0];
                `BCR_IDX_GREEN: green_gain_q <= pwdata[7:0];
                `BCR_IDX_BLUE: blue_gain_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // conversion result; low byte snapshot taken when the high part is read
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            result_q <= `BCR_RST_RESULT;
            low_shadow_q <= 8'h00;
            snap_hold_q <= 1'b0;
        end else begin
            if (conv_valid) begin
                result_q <= conv_result;
            end
            // a high read freezes the low byte until the matching low read completes
            if (rd_hi) begin
                low_shadow_q <= result_q[7:0];
                snap_hold_q <= 1'b1;
            end else if (rd_lo) begin
                snap_hold_q <= 1'b0;
                low_shadow_q <= conv_valid ? conv_result[7:0] : result_q[7:0];
            end else if (conv_valid && !snap_hold_q) begin
                low_shadow_q <= conv_result[7:0];
            end
        end
    end

    // control outputs derived from the registers
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bright_gate_q <= 1'b0;
            bright_scale_q <= 8'h80;
            bright_ext_q <= 1'b1;
            boost_code_q <= `BCR_VPROG_MIN;
            boost_adaptive_q <= 1'b1;
            boost_enable_q <= 1'b0;
            autoload_q <= 1'b0;
            comp_sensor_source_q <= 1'b0;
            sensor_select_q <= 1'b0;
            active_q <= 1'b0;
        end else begin
            bright_ext_q <= !bright_reg_q[`BCR_BRC_OFF_BIT];
            if (bright_reg_q[`BCR_BRC_OFF_BIT]) begin
                bright_gate_q <= ctrl_reg_q[`BCR_NSTBY_BIT];
                bright_scale_q <= 8'h01 << bright_reg_q[`BCR_BRI_MSB:`BCR_BRI_LSB];
            end else begin
                bright_gate_q <= pin_level && ctrl_reg_q[`BCR_NSTBY_BIT];
                bright_scale_q <= 8'h80;
            end
            boost_code_q <= bcr_clamp_boost(boost_reg_q[`BCR_VPROG_MSB:0]);
            boost_adaptive_q <= ctrl_reg_q[`BCR_VOUT_AUTO_BIT];
            boost_enable_q <= ctrl_reg_q[`BCR_EN_BOOST_BIT] && ctrl_reg_q[`BCR_NSTBY_BIT];
            autoload_q <= ctrl_reg_q[`BCR_AUTOLOAD_BIT];
            comp_sensor_source_q <= ctrl_reg_q[`BCR_COMP_SRC_BIT];
            sensor_select_q <= ctrl_reg_q[`BCR_SENS_SEL_BIT];
            active_q <= ctrl_reg_q[`BCR_NSTBY_BIT];
        end
    end
endmodule // bcr_top

`default_nettype wire

// ---- verif/backlight_config_registers_bench.sv ----
`include "bcr_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module backlight_config_registers_bench;
    logic sys_clk, rst_b, brightness_pin, conv_valid;
    logic [11:0] conv_result;
    wire psel, penable, pwrite, pready, pslverr;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [3:0] pstrb;
    wire bright_gate_q, bright_ext_q, boost_adaptive_q, boost_enable_q, autoload_q;
    wire comp_sensor_source_q, sensor_select_q, active_q;
    wire [7:0] bright_scale_q, red_gain_q, green_gain_q, blue_gain_q;
    wire [4:0] boost_code_q;
    int errors, tests_run;
    logic [31:0] v;
    logic x;
    bcr_top dut (.*);
    bcr_host host (.*);
    // compare and count
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task rd(input logic [5:0] i, input logic [7:0] e);
        host.xfer(1'b0, {4'h0, i, 2'b00}, 8'h00, v, x);
        chk("read data", {24'h00_0000, e}, v);
    endtask
    task wr(input logic [5:0] i, input logic [7:0] d);
        host.xfer(1'b1, {4'h0, i, 2'b00}, d, v, x);
        repeat (2) @(posedge sys_clk);
    endtask
    task conv(input logic [11:0] c);
        @(posedge sys_clk);
        conv_result <= c;
        conv_valid <= 1'b1;
        @(posedge sys_clk);
        conv_valid <= 1'b0;
    endtask
    task t_reset;
        rd(`BCR_IDX_BRIGHT, 8'h00);
        rd(`BCR_IDX_CTRL, 8'h04);
        rd(`BCR_IDX_RES_HI, 8'h00);
        rd(`BCR_IDX_BLUE, 8'h80);
        host.xfer(1'b0, 12'h01c, 8'h00, v, x);
        chk("unmapped error", 1'b1, x);
    endtask
    task t_fields;
        wr(`BCR_IDX_BOOST, 8'hff);
        wr(`BCR_IDX_CTRL, 8'hff);
        rd(`BCR_IDX_BOOST, 8'h1f);
        rd(`BCR_IDX_CTRL, 8'h3f);
        chk("boost code", 5'h14, boost_code_q);
        chk("controls", 6'h3f, {autoload_q, boost_enable_q, comp_sensor_source_q, sensor_select_q, boost_adaptive_q, active_q});
        wr(`BCR_IDX_BOOST, 8'h09);
        wr(`BCR_IDX_CTRL, 8'h02);
        chk("boost code", 5'h09, boost_code_q);
        chk("controls", 3'b000, {boost_enable_q, boost_adaptive_q, active_q});
    endtask
    task t_levels;
        wr(`BCR_IDX_CTRL, 8'h01);
        for (int i = 0; i < 8; i++) begin
            wr(`BCR_IDX_BRIGHT, 8'h10 | i[7:0]);
            chk("level scale", 8'h01 << i, bright_scale_q);
        end
        rd(`BCR_IDX_BRIGHT, 8'h17);
        wr(`BCR_IDX_BRIGHT, 8'h00);
        for (int p = 1; p >= 0; p--) begin
            brightness_pin <= p[0];
            repeat (6) @(posedge sys_clk);
            chk("pin gate", p[0], bright_gate_q);
        end
    endtask
    task t_result;
        conv(12'habc);
        rd(`BCR_IDX_RES_HI, 8'h0a);
        conv(12'h123);
        rd(`BCR_IDX_RES_LO, 8'hbc);
        wr(`BCR_IDX_RES_HI, 8'hff);
        rd(`BCR_IDX_RES_HI, 8'h01);
    endtask
    task t_gains;
        wr(`BCR_IDX_RED, 8'hff);
        wr(`BCR_IDX_GREEN, 8'h01);
        chk("gains", 24'hff_0180, {red_gain_q, green_gain_q, blue_gain_q});
        rd(`BCR_IDX_RED, 8'hff);
    endtask
    task stop_test;
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // main sequence
    initial begin
        rst_b = 1'b0;
        brightness_pin = 1'b0;
        conv_valid = 1'b0;
        conv_result = 12'h000;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_fields();
        t_levels();
        t_result();
        t_gains();
        stop_test();
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        stop_test();
    end
endmodule // backlight_config_registers_bench
`default_nettype wire

// ---- verif/bcr_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module bcr_host (
    input wire logic sys_clk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
    end
    // one transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // bcr_host
`default_nettype wire

// ---- verif/bcr_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module bcr_sva (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic bright_gate_q,
    input wire logic [7:0] bright_scale_q,
    input wire logic bright_ext_q,
    input wire logic [4:0] boost_code_q,
    input wire logic boost_adaptive_q,
    input wire logic boost_enable_q,
    input wire logic active_q,
    input wire logic [7:0] red_gain_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // output relations and bus timing
    pin_scale_a: assert property (bright_ext_q |-> bright_scale_q == 8'h80)
        else $error("pin mode scale wrong");
    level_onehot_a: assert property (!bright_ext_q |-> $onehot(bright_scale_q))
        else $error("level scale not one-hot");
    boost_range_a: assert property (boost_code_q >= 5'h05 && boost_code_q <= 5'h14)
        else $error("boost code out of range");
    boost_gate_a: assert property (boost_enable_q |-> active_q)
        else $error("boost on in standby");
    standby_gate_a: assert property (!active_q |-> !bright_gate_q)
        else $error("brightness on in standby");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    hi_nibble_a: assert property (pready && !pwrite && paddr == 12'h020 |-> prdata[7:4] == 4'h0)
        else $error("result high upper nibble set");
    reset_val_a: assert property ($rose(rst_b) |-> boost_adaptive_q && !active_q && red_gain_q == 8'h80)
        else $error("reset values wrong");
    wait_state_a: assert property (psel && penable && !$past(penable) |=> pready ##1 !pready)
        else $error("answer timing wrong");
    err_pair_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    cover property (pslverr);
    cover property (pready && paddr == 12'h024);
    cover property (boost_enable_q);
endmodule // bcr_sva
bind bcr_top bcr_sva u_sva (.*);
`default_nettype wire
